// >>> rtl/udb_pkg.sv
// constants shared by the uart data buffer and its baud generator
package udb_pkg;
   localparam logic [7:0] UDB_BUF_ADDR      = 8'h99;
   localparam logic [7:0] UDB_BUF_RESET     = 8'h00;

   localparam logic [1:0] UDB_PRE_DIV12     = 2'h0;
   localparam logic [1:0] UDB_PRE_DIV4      = 2'h1;
   localparam logic [1:0] UDB_PRE_DIV48     = 2'h2;
   localparam logic [1:0] UDB_PRE_EXT8      = 2'h3;
   localparam logic [5:0] UDB_DIV12_LAST    = 6'h0b;
   localparam logic [5:0] UDB_DIV4_LAST     = 6'h03;
   localparam logic [5:0] UDB_DIV48_LAST    = 6'h2f;
   localparam logic [5:0] UDB_EXT8_LAST     = 6'h07;

   // reload values for the standard rates with direct core clocking; the 9K6 value needs the divide-by-12 prescaler
   localparam logic [7:0] UDB_RLD_245_230K  = 8'hcb;
   localparam logic [7:0] UDB_RLD_245_115K  = 8'h96;
   localparam logic [7:0] UDB_RLD_245_57K   = 8'h2b;
   localparam logic [7:0] UDB_RLD_221_230K  = 8'hd0;
   localparam logic [7:0] UDB_RLD_221_115K  = 8'ha0;
   localparam logic [7:0] UDB_RLD_221_57K   = 8'h40;
   localparam logic [7:0] UDB_RLD_221_9K6   = 8'ha0;

   localparam logic [3:0] UDB_BITS_8        = 4'h8;
   localparam logic [3:0] UDB_BITS_9        = 4'h9;

   typedef enum logic [4:0] {
      UDB_TX_IDLE  = 5'b00001,
      UDB_TX_LOAD  = 5'b00010,
      UDB_TX_START = 5'b00100,
      UDB_TX_DATA  = 5'b01000,
      UDB_TX_STOP  = 5'b10000
   } udb_tx_state_t;

   typedef enum logic [3:0] {
      UDB_RX_IDLE  = 4'b0001,
      UDB_RX_START = 4'b0010,
      UDB_RX_DATA  = 4'b0100,
      UDB_RX_STOP  = 4'b1000
   } udb_rx_state_t;
endpackage : udb_pkg

// >>> rtl/udb_tick_if.sv
// tick signals from the baud generator to the uart core
`timescale 1ns/1ps
`default_nettype none
interface udb_tick_if;
   logic ovf;
   logic bit_tick;
   modport gen  (output ovf, output bit_tick);
   modport user (input  ovf, input  bit_tick);
endinterface : udb_tick_if
`default_nettype wire

// >>> rtl/udb_baud_gen.sv
// prescaler and auto-reload baud timer
`timescale 1ns/1ps
`default_nettype none
module udb_baud_gen
   import udb_pkg::*;
#(
   parameter int TIMER_W = 8
) (
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   input  wire logic               timer_clock_sel_i,
   input  wire logic [1:0]         prescale_sel_i,
   input  wire logic [TIMER_W-1:0] reload_i,
   input  wire logic               ext_clk_i,
   udb_tick_if.gen                 tick
);
   if (TIMER_W < 2 || TIMER_W > 16) begin : g_bad_timer_w
      $error("udb_baud_gen: TIMER_W out of range");
   end

   logic               ext_q;
   logic [5:0]         pre_cnt;
   logic [5:0]         pre_last;
   logic               pre_event;
   logic               timer_en;
   logic [TIMER_W-1:0] timer;
   logic               half;

   always_comb begin
      pre_event = 1'b1;
      case (prescale_sel_i)
         UDB_PRE_DIV12: pre_last = UDB_DIV12_LAST;
         UDB_PRE_DIV4:  pre_last = UDB_DIV4_LAST;
         UDB_PRE_DIV48: pre_last = UDB_DIV48_LAST;
         UDB_PRE_EXT8: begin
            pre_last  = UDB_EXT8_LAST;
            pre_event = ext_clk_i & ~ext_q;
         end
         default:       pre_last = UDB_DIV12_LAST;
      endcase
   end

   // direct clocking bypasses the prescaler entirely
   assign timer_en = timer_clock_sel_i | (pre_event && pre_cnt == pre_last);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_q <= 1'b0;
      end else begin
         ext_q <= ext_clk_i;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pre_cnt <= 6'h00;
      end else if (pre_event) begin
         pre_cnt <= (pre_cnt >= pre_last) ? 6'h00 : pre_cnt + 6'h01;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         timer    <= '0;
         tick.ovf <= 1'b0;
      end else begin
         tick.ovf <= 1'b0;
         if (timer_en) begin
            if (&timer) begin
               timer    <= reload_i;
               tick.ovf <= 1'b1;
            end else begin
               timer <= timer + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         half          <= 1'b0;
         tick.bit_tick <= 1'b0;
      end else begin
         tick.bit_tick <= 1'b0;
         if (tick.ovf) begin
            half          <= ~half;
            tick.bit_tick <= half;
         end
      end
   end
endmodule : udb_baud_gen
`default_nettype wire

// >>> rtl/udb_uart.sv
// uart data buffer: sfr access, transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module udb_uart
   import udb_pkg::*;
#(
   parameter int TIMER_W = 8
) (
   input  wire logic               clk_i,
   input  wire logic               arst_n_i,
   input  wire logic [7:0]         sfr_addr_i,
   input  wire logic               sfr_wr_i,
   input  wire logic               sfr_rd_i,
   input  wire logic [7:0]         sfr_wdata_i,
   output logic      [7:0]         sfr_rdata_o,
   input  wire logic               baud_timer_clock_select_i,
   input  wire logic [1:0]         timer_prescale_select_i,
   input  wire logic [TIMER_W-1:0] baud_reload_i,
   input  wire logic               external_osc_clock_i,
   input  wire logic               word_length_select_i,
   input  wire logic               rx_enable_bit_i,
   input  wire logic               multiproc_check_enable_i,
   input  wire logic               tx_ninth_bit_i,
   input  wire logic               tx_done_clear_i,
   input  wire logic               rx_done_clear_i,
   output logic                    tx_done_flag_o,
   output logic                    rx_done_flag_o,
   output logic                    rx_ninth_bit_o,
   output logic                    tx_busy_o,
   output logic                    txd_o,
   input  wire logic               rxd_i
);
   udb_tick_if tick_bus ();

   udb_baud_gen #(
      .TIMER_W (TIMER_W)
   ) u_baud (
      .clk_i             (clk_i),
      .arst_n_i          (arst_n_i),
      .timer_clock_sel_i (baud_timer_clock_select_i),
      .prescale_sel_i    (timer_prescale_select_i),
      .reload_i          (baud_reload_i),
      .ext_clk_i         (external_osc_clock_i),
      .tick              (tick_bus.gen)
   );

   logic          buf_hit;
   logic          buf_write;
   logic [3:0]    frame_bits;
   udb_tx_state_t tx_state;
   logic [8:0]    tx_shift;
   logic [3:0]    tx_cnt;
   logic          tx_done_set;
   udb_rx_state_t rx_state;
   logic [8:0]    rx_shift;
   logic [3:0]    rx_cnt;
   logic          rx_phase;
   logic          rxd_q;
   logic          rx_accept;
   logic          rx_qualifier;
   logic [7:0]    rx_latch;
   logic          rx_done_set;

   assign buf_hit    = (sfr_addr_i == UDB_BUF_ADDR);
   assign buf_write  = buf_hit & sfr_wr_i;
   assign frame_bits = word_length_select_i ? UDB_BITS_9 : UDB_BITS_8;

   // bus read returns the receive latch only; transmit data is never visible
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sfr_rdata_o <= UDB_BUF_RESET;
      end else begin
         sfr_rdata_o <= (buf_hit && sfr_rd_i) ? rx_latch : UDB_BUF_RESET;
      end
   end

   // transmitter: frames start on the next bit tick after the write
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_state    <= UDB_TX_IDLE;
         tx_shift    <= 9'h000;
         tx_cnt      <= 4'h0;
         txd_o       <= 1'b1;
         tx_done_set <= 1'b0;
      end else begin
         tx_done_set <= 1'b0;
         case (tx_state)
            UDB_TX_IDLE: begin
               // a write while a frame is running is dropped so the line never glitches
               if (buf_write) begin
                  tx_shift <= {tx_ninth_bit_i, sfr_wdata_i};
                  tx_state <= UDB_TX_LOAD;
               end
            end
            UDB_TX_LOAD: begin
               if (tick_bus.bit_tick) begin
                  txd_o    <= 1'b0;
                  tx_cnt   <= 4'h0;
                  tx_state <= UDB_TX_START;
               end
            end
            UDB_TX_START: begin
               if (tick_bus.bit_tick) begin
                  txd_o    <= tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[8:1]};
                  tx_cnt   <= 4'h1;
                  tx_state <= UDB_TX_DATA;
               end
            end
            UDB_TX_DATA: begin
               if (tick_bus.bit_tick) begin
                  if (tx_cnt == frame_bits) begin
                     txd_o       <= 1'b1;
                     tx_done_set <= 1'b1;
                     tx_state    <= UDB_TX_STOP;
                  end else begin
                     txd_o    <= tx_shift[0];
                     tx_shift <= {1'b0, tx_shift[8:1]};
                     tx_cnt   <= tx_cnt + 4'h1;
                  end
               end
            end
            UDB_TX_STOP: begin
               if (tick_bus.bit_tick) begin
                  tx_state <= UDB_TX_IDLE;
               end
            end
            default: begin
               tx_state <= UDB_TX_IDLE;
               txd_o    <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_busy_o <= 1'b0;
      end else begin
         tx_busy_o <= (tx_state != UDB_TX_IDLE) || buf_write;
      end
   end

   // hardware set wins over a simultaneous software clear
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_done_flag_o <= 1'b0;
      end else if (tx_done_set) begin
         tx_done_flag_o <= 1'b1;
      end else if (tx_done_clear_i) begin
         tx_done_flag_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rxd_q <= 1'b1;
      end else begin
         rxd_q <= rxd_i;
      end
   end

   // stop bit in 8-bit mode, ninth bit in 9-bit mode, gates the flag when checking is on
   assign rx_qualifier = word_length_select_i ? rx_shift[8] : rxd_i;
   assign rx_accept    = ~multiproc_check_enable_i | rx_qualifier;

   // receiver: mid-bit sampling uses one overflow, half a bit; phase error is one overflow
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_state    <= UDB_RX_IDLE;
         rx_shift    <= 9'h000;
         rx_cnt      <= 4'h0;
         rx_phase    <= 1'b0;
         rx_latch    <= UDB_BUF_RESET;
         rx_done_set <= 1'b0;
         rx_ninth_bit_o <= 1'b0;
      end else begin
         rx_done_set <= 1'b0;
         case (rx_state)
            UDB_RX_IDLE: begin
               if (rx_enable_bit_i && rxd_q && !rxd_i) begin
                  rx_state <= UDB_RX_START;
               end
            end
            UDB_RX_START: begin
               if (!rx_enable_bit_i) begin
                  rx_state <= UDB_RX_IDLE;
               end else if (tick_bus.ovf) begin
                  if (rxd_i) begin
                     rx_state <= UDB_RX_IDLE;
                  end else begin
                     rx_phase <= 1'b0;
                     rx_cnt   <= 4'h0;
                     rx_shift <= 9'h000;
                     rx_state <= UDB_RX_DATA;
                  end
               end
            end
            UDB_RX_DATA: begin
               if (!rx_enable_bit_i) begin
                  rx_state <= UDB_RX_IDLE;
               end else if (tick_bus.ovf) begin
                  rx_phase <= ~rx_phase;
                  if (rx_phase) begin
                     if (word_length_select_i) begin
                        rx_shift <= {rxd_i, rx_shift[8:1]};
                     end else begin
                        rx_shift <= {1'b0, rxd_i, rx_shift[7:1]};
                     end
                     rx_cnt <= rx_cnt + 4'h1;
                     if (rx_cnt + 4'h1 == frame_bits) begin
                        rx_state <= UDB_RX_STOP;
                     end
                  end
               end
            end
            UDB_RX_STOP: begin
               if (!rx_enable_bit_i) begin
                  rx_state <= UDB_RX_IDLE;
               end else if (tick_bus.ovf) begin
                  rx_phase <= ~rx_phase;
                  if (rx_phase) begin
                     rx_state <= UDB_RX_IDLE;
                     if (rx_accept) begin
                        rx_latch       <= rx_shift[7:0];
                        rx_ninth_bit_o <= rx_qualifier;
                        rx_done_set    <= 1'b1;
                     end
                  end
               end
            end
            default: begin
               rx_state <= UDB_RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rx_done_flag_o <= 1'b0;
      end else if (rx_done_set) begin
         rx_done_flag_o <= 1'b1;
      end else if (rx_done_clear_i) begin
         rx_done_flag_o <= 1'b0;
      end
   end
endmodule : udb_uart
`default_nettype wire

// >>> testbench/udb_uart_checker.sv
// port-level assertions for the uart data buffer
`timescale 1ns/1ps
`default_nettype none
module udb_uart_checker
   import udb_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       arst_n_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic       sfr_wr_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic       rx_enable_bit_i,
   input wire logic       tx_done_clear_i,
   input wire logic       rx_done_clear_i,
   input wire logic       tx_done_flag_o,
   input wire logic       rx_done_flag_o,
   input wire logic       tx_busy_o,
   input wire logic       txd_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i);
   wire logic wr_hit = sfr_wr_i && sfr_addr_i == UDB_BUF_ADDR;
   a_rdata_quiet: assert property (!(sfr_rd_i && sfr_addr_i == UDB_BUF_ADDR) |=> sfr_rdata_o == 8'h00)
      else $error("read data not zero without a read hit");
   a_write_starts: assert property (wr_hit && !tx_busy_o |=> tx_busy_o)
      else $error("buffer write did not start a frame");
   a_other_addr: assert property (sfr_wr_i && !wr_hit && !tx_busy_o |=> !tx_busy_o)
      else $error("write elsewhere started a frame");
   a_line_idle: assert property (!tx_busy_o |-> txd_o)
      else $error("serial line low while idle");
   a_busy_holds: assert property ($rose(tx_busy_o) |-> tx_busy_o [*8])
      else $error("frame ended too soon");
   a_txdone_stop: assert property ($rose(tx_done_flag_o) |-> txd_o && tx_busy_o)
      else $error("transmit done outside the stop bit");
   a_txdone_sticky: assert property (tx_done_flag_o && !tx_done_clear_i |=> tx_done_flag_o)
      else $error("transmit done dropped by itself");
   a_txdone_clear: assert property (tx_done_flag_o && tx_done_clear_i && !tx_busy_o |=> !tx_done_flag_o)
      else $error("transmit done not cleared");
   a_rxdone_sticky: assert property (rx_done_flag_o && !rx_done_clear_i |=> rx_done_flag_o)
      else $error("receive done dropped by itself");
   // a stop sample taken just before the disable still raises the flag two cycles later
   a_rx_disabled: assert property (!rx_enable_bit_i ##1 !rx_enable_bit_i |=> !$rose(rx_done_flag_o))
      else $error("frame received while disabled");
   c_tx_done: cover property ($rose(tx_done_flag_o));
   c_rx_done: cover property ($rose(rx_done_flag_o));
   c_write: cover property (wr_hit && !tx_busy_o);
endmodule // udb_uart_checker
bind udb_uart udb_uart_checker u_chk (.clk_i, .arst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o,
   .rx_enable_bit_i, .tx_done_clear_i, .rx_done_clear_i, .tx_done_flag_o, .rx_done_flag_o, .tx_busy_o, .txd_o);
`default_nettype wire

// >>> testbench/udb_serial_peer.sv
// remote serial device: drives frames on rxd and captures frames from txd
`timescale 1ns/1ps
`default_nettype none
module udb_serial_peer (
   input  wire logic clk_i,
   input  wire logic txd_i,
   output var  logic rxd_o
);
   int         bit_clks = 16;
   int         nbits = 8;
   logic [8:0] got = 9'h000;
   initial rxd_o = 1'b1;
   // start low, data lsb first, stop high; line rests high
   task automatic send(input logic [8:0] d, input int n);
      @(posedge clk_i);
      for (int i = 0; i < n + 2; i++) begin
         rxd_o <= i == 0 ? 1'b0 : i == n + 1 ? 1'b1 : d[i-1];
         repeat (bit_clks) @(posedge clk_i);
      end
   endtask
   // samples mid-bit, so a late first tick in the design does not matter
   always begin
      @(negedge txd_i);
      got = 9'h000;
      repeat (bit_clks + bit_clks / 2) @(posedge clk_i);
      for (int i = 0; i < nbits; i++) begin
         got[i] = txd_i;
         repeat (bit_clks) @(posedge clk_i);
      end
   end
endmodule // udb_serial_peer
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the uart data buffer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb_top;
   import udb_pkg::*;
   logic       clk_i = 1'b0;
   logic       arst_n_i = 1'b0;
   logic [7:0] sfr_addr_i = 8'h00;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] baud_reload_i = 8'hf8;
   logic [1:0] timer_prescale_select_i = 2'h0;
   logic [1:0] ext_div = 2'h0;
   logic       sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, baud_timer_clock_select_i = 1'b1, word_length_select_i = 1'b0;
   logic       rx_enable_bit_i = 1'b1, tx_ninth_bit_i = 1'b0, tx_done_clear_i = 1'b0, rx_done_clear_i = 1'b0;
   logic       multiproc_check_enable_i = 1'b0;
   logic [7:0] sfr_rdata_o;
   logic       tx_done_flag_o, rx_done_flag_o, rx_ninth_bit_o, tx_busy_o, txd_o;
   wire logic  rxd_i;
   int         failures = 0;
   int         compares = 0;
   int         cycles = 0;
   logic [10:0] bt [11] = '{11'h4cb, 11'h496, 11'h42b, 11'h4d0, 11'h4a0, 11'h440, 11'h4f8, 11'h1fe, 11'h0a0,
                           11'h2fe, 11'h3fe};
   udb_uart #(.TIMER_W(8)) u_dut (.clk_i, .arst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
      .baud_timer_clock_select_i, .timer_prescale_select_i, .baud_reload_i, .external_osc_clock_i(ext_div[1]),
      .word_length_select_i, .rx_enable_bit_i, .multiproc_check_enable_i, .tx_ninth_bit_i, .tx_done_clear_i,
      .rx_done_clear_i, .tx_done_flag_o, .rx_done_flag_o, .rx_ninth_bit_o, .tx_busy_o, .txd_o, .rxd_i);
   udb_serial_peer u_peer (.clk_i, .txd_i(txd_o), .rxd_o(rxd_i));
   always #4 clk_i = ~clk_i;
   // external oscillator at a quarter of the core rate
   always @(posedge clk_i) ext_div <= ext_div + 2'h1;
   task automatic complete_run();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 90000) begin
         failures++;
         complete_run();
      end
   end
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask
   // strobes rise at one edge and drop at the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_wdata_i <= d;
      sfr_wr_i <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i <= 1'b1;
      @(posedge clk_i);
      sfr_rd_i <= 1'b0;
      #1;
      d = sfr_rdata_o;
   endtask
   task automatic clr();
      @(posedge clk_i);
      tx_done_clear_i <= 1'b1;
      rx_done_clear_i <= 1'b1;
      @(posedge clk_i);
      tx_done_clear_i <= 1'b0;
      rx_done_clear_i <= 1'b0;
      step();
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 30000 && tx_busy_o !== 1'b0; i++) step();
   endtask
   initial begin
      logic [7:0] d;
      int         n, dv, ex;
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      rd(UDB_BUF_ADDR, d);
      `CHK("buffer reset", UDB_BUF_RESET, d)
      wr(UDB_BUF_ADDR, 8'ha5);
      wait_idle();
      `CHK("tx byte", 9'h0a5, u_peer.got)
      `CHK("tx done", 1'b1, tx_done_flag_o)
      rd(UDB_BUF_ADDR, d);
      `CHK("latch after tx", 8'h00, d)
      clr();
      `CHK("tx done cleared", 1'b0, tx_done_flag_o)
      u_peer.send(9'h03c, 8);
      step();
      `CHK("rx done", 1'b1, rx_done_flag_o)
      rd(UDB_BUF_ADDR, d);
      `CHK("rx latch", 8'h3c, d)
      rd(8'h98, d);
      `CHK("unmapped read", 8'h00, d)
      wr(8'h98, 8'h77);
      `CHK("unmapped write", 1'b0, tx_busy_o)
      @(posedge clk_i);
      rx_enable_bit_i <= 1'b0;
      clr();
      u_peer.send(9'h055, 8);
      step();
      `CHK("rx disabled flag", 1'b0, rx_done_flag_o)
      rd(UDB_BUF_ADDR, d);
      `CHK("rx disabled latch", 8'h3c, d)
      @(posedge clk_i);
      rx_enable_bit_i <= 1'b1;
      word_length_select_i <= 1'b1;
      tx_ninth_bit_i <= 1'b1;
      u_peer.nbits = 9;
      wr(UDB_BUF_ADDR, 8'h81);
      wait_idle();
      `CHK("tx nine bits", 9'h181, u_peer.got)
      clr();
      u_peer.send(9'h1c3, 9);
      step();
      `CHK("rx ninth bit", 1'b1, rx_ninth_bit_o)
      rd(UDB_BUF_ADDR, d);
      `CHK("rx nine bits", 8'hc3, d)
      // with checking on, only frames whose ninth bit is set raise the flag
      clr();
      @(posedge clk_i);
      multiproc_check_enable_i <= 1'b1;
      u_peer.send(9'h044, 9);
      step();
      `CHK("check drop flag", 1'b0, rx_done_flag_o)
      u_peer.send(9'h155, 9);
      step();
      `CHK("check accept flag", 1'b1, rx_done_flag_o)
      rd(UDB_BUF_ADDR, d);
      `CHK("check accept latch", 8'h55, d)
      @(posedge clk_i);
      multiproc_check_enable_i <= 1'b0;
      word_length_select_i <= 1'b0;
      u_peer.nbits = 8;
      // start bit length equals one bit period for every clock source
      for (int k = 0; k < 11; k++) begin
         @(posedge clk_i);
         {baud_timer_clock_select_i, timer_prescale_select_i, baud_reload_i} <= bt[k];
         dv = bt[k][10] ? 1 : bt[k][9:8] == 2'h0 ? 12 : bt[k][9:8] == 2'h1 ? 4 : bt[k][9:8] == 2'h2 ? 48 : 32;
         ex = 2 * (256 - int'(bt[k][7:0])) * dv;
         u_peer.bit_clks = ex;
         repeat (70) @(posedge clk_i);
         wr(UDB_BUF_ADDR, 8'h01);
         for (int i = 0; i < 5000 && txd_o !== 1'b0; i++) step();
         n = 0;
         while (txd_o === 1'b0 && n < 5000) begin
            step();
            n++;
         end
         `CHK("bit period", ex, n)
         wait_idle();
         `CHK("rate byte", 9'h001, u_peer.got)
      end
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
